// ### core/ibed_defines.svh
// Constants for the burst end detector: timing, register map, field positions and reset values.
`ifndef IBED_DEFINES_SVH
`define IBED_DEFINES_SVH

`define IBED_CLK_PERIOD_NS 25
`define IBED_TICK_TIME_NS  1000000
`define IBED_DT_UNIT_MS    17'h0000A
`define IBED_DIV_W         20
`define IBED_MS_W          17
`define IBED_BUF_AW        4
`define IBED_ADDR_W        5

`define IBED_REG_CTRL      5'h00
`define IBED_REG_SVC_PID   5'h04
`define IBED_REG_MAX_DUR   5'h08
`define IBED_REG_WAKE_LEAD 5'h0C
`define IBED_REG_STATUS    5'h10
`define IBED_REG_IRQ_MASK  5'h14
`define IBED_REG_STATE     5'h18

`define IBED_CTRL_EN       0
`define IBED_CTRL_PROT     1

`define IBED_ST_DONE       0
`define IBED_ST_TS_END     1
`define IBED_ST_IFEC_END   2
`define IBED_ST_LATE       3
`define IBED_ST_TIMEOUT    4
`define IBED_ST_SVC        5
`define IBED_ST_OVF        6
`define IBED_ST_W          7

`define IBED_MAX_DUR_RST   16'h00C8
`define IBED_WAKE_LEAD_RST 8'h05

`endif

// ### core/ibed_pkg.sv
// Types shared by the burst end detector files.
package ibed_pkg;
`include "ibed_defines.svh"

	typedef struct packed {
		logic [`IBED_DIV_W-1:0]  div;
		logic [`IBED_MS_W-1:0]   anc_ms;
		logic [11:0]             anc_dt;
		logic                    anc_ok;
		logic [`IBED_MS_W-1:0]   ref_ms;
		logic [11:0]             ref_dt;
		logic                    in_burst;
		logic                    ts_end;
		logic                    ifec_end;
		logic                    fe_on;
		logic                    known;
		logic [7:0]              bnum;
		logic [`IBED_BUF_AW-1:0] wptr;
		logic [`IBED_BUF_AW-1:0] rptr;
		logic [`IBED_BUF_AW:0]   count;
		logic                    rd_pend;
		logic                    rel_valid;
		logic [7:0]              rel_tag;
		logic [7:0]              rel_num;
		logic                    acc;
		logic                    disc;
		logic                    done;
		logic [1:0]              ctrl;
		logic [12:0]             pid;
		logic [15:0]             max_ms;
		logic [7:0]              lead;
		logic [`IBED_ST_W-1:0]   status;
		logic [`IBED_ST_W-1:0]   mask;
		logic                    wreq;
		logic [31:0]             rdata;
		logic                    irq;
	} ibed_state_t;
endpackage

// ### core/ibed_tag_ram.sv
// Small buffer memory for tags of data sections whose burst number is not yet known.
`timescale 1ns/100ps
module ibed_tag_ram #(
	parameter int AW = 4,
	parameter int DW = 8
) (
	// Clock and reset.
	input  wire logic          clk,
	input  wire logic          reset,
	// Write port.
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [DW-1:0] wr_data,
	// Read port, data registered.
	input  wire logic          rd_en,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [DW-1:0] rd_data
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rd_data <= '0;
		end else if (rd_en) begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule

// ### core/ibed_burst_end_detector.sv
// Burst end detector for one stream of data sections mixed with parity sections.
// Notes on behaviour
// RQ1: Offset in every section targets next data burst.
// RQ2: Early parity may be missed; wake ahead.
// RQ3: Sender keeps data start within 1 ms.
// RQ4: Sender should open bursts with data.
// RQ5: Sender puts parity early for burst number.
// RQ6: Hold data until burst number is resolved.
// RQ7: Sender stops all sections after max duration.
// RQ8: Drop late sections; front end may sleep.
// RQ9: Burst over only when both ends seen; an unprotected stream is declared over at the data end alone.
// RQ10: Data boundary flag ends data burst.
// RQ11: Parity data-boundary flag ends data burst.
// RQ12: Parity frame flag ends parity burst.
// RQ13: Timeout after offset plus max duration.
// RQ14: Protected stream stays on for other kind.
// RQ15: Unprotected stream sleeps after last data.
// RQ16: Foreign service identifier ends both bursts.
// RQ17: Offset counts from this section's packet start.
//
// The Avalon-MM interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
`include "ibed_defines.svh"
module ibed_burst_end_detector
	import ibed_pkg::*;
#(
	parameter int TICK_CYC = `IBED_TICK_TIME_NS / `IBED_CLK_PERIOD_NS
) (
	// Clock and reset.
	input  wire logic                    clk,
	input  wire logic                    reset,
	// Parsed section headers, one pulse per section.
	input  wire logic                    sec_valid,
	input  wire logic                    sec_is_parity,
	input  wire logic [12:0]             sec_pid,
	input  wire logic                    sec_table_bnd,
	input  wire logic                    sec_mpe_bnd,
	input  wire logic                    sec_frame_bnd,
	input  wire logic [11:0]             sec_delta_t,
	input  wire logic [7:0]              sec_burst_num,
	input  wire logic [7:0]              sec_tag,
	// Section verdicts and placed data sections.
	output logic                         sec_accept,
	output logic                         sec_discard,
	output logic                         rel_valid,
	output logic [7:0]                   rel_tag,
	output logic [7:0]                   rel_burst_num,
	// Power and burst status.
	output logic                         frontend_on,
	output logic                         burst_done,
	output logic                         irq,
	// Avalon-MM slave.
	input  wire logic [`IBED_ADDR_W-1:0] avs_address,
	input  wire logic                    avs_read,
	input  wire logic                    avs_write,
	input  wire logic [31:0]             avs_writedata,
	input  wire logic [3:0]              avs_byteenable,
	output logic [31:0]                  avs_readdata,
	output logic                         avs_waitrequest
);
	import ibed_pkg::*;

	localparam logic [`IBED_BUF_AW:0] BUF_FULL = {1'b1, {`IBED_BUF_AW{1'b0}}};

	ibed_state_t                  s;
	ibed_state_t                  n;
	logic                         tick;
	logic                         en;
	logic                         prot;
	logic                         late;
	logic                         stale;
	logic                         due;
	logic                         push;
	logic                         rd_en;
	logic [`IBED_MS_W-1:0]        limit;
	logic [`IBED_ST_W-1:0]        ev;
	logic [`IBED_ST_W-1:0]        clr;
	logic [31:0]                  wmask;
	logic [7:0]                   ram_q;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [31:0] m);
		merge = (old & ~m) | (wd & m);
	endfunction

	ibed_tag_ram #(
		.AW (`IBED_BUF_AW),
		.DW (8)
	) u_ram (
		.clk     (clk),
		.reset   (reset),
		.wr_en   (push),
		.wr_addr (s.wptr),
		.wr_data (sec_tag),
		.rd_en   (rd_en),
		.rd_addr (s.rptr),
		.rd_data (ram_q)
	);

	always_comb begin
		n = s;
		n.acc = 1'b0;
		n.disc = 1'b0;
		n.done = 1'b0;
		n.rel_valid = 1'b0;
		n.rd_pend = 1'b0;
		ev = '0;
		clr = '0;
		push = 1'b0;
		rd_en = 1'b0;
		en = s.ctrl[`IBED_CTRL_EN];
		prot = s.ctrl[`IBED_CTRL_PROT];
		wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
		tick = (s.div == `IBED_DIV_W'(TICK_CYC - 1));
		n.div = tick ? '0 : s.div + 1'b1;
		// Millisecond counters saturate so an idle stream never wraps into a false wake.
		if (tick && !(&s.anc_ms)) begin
			n.anc_ms = s.anc_ms + 1'b1;
		end
		if (tick && !(&s.ref_ms)) begin
			n.ref_ms = s.ref_ms + 1'b1;
		end
		limit = {5'h00, s.ref_dt} * `IBED_DT_UNIT_MS + {1'b0, s.max_ms};
		late = s.in_burst && (s.ref_ms > limit);
		due = ({5'h00, s.anc_dt} * `IBED_DT_UNIT_MS) <= (s.anc_ms + {9'h000, s.lead});
		// Past the duration limit and before the next burst is due, nothing on the stream is live.
		stale = (s.ref_ms > limit) && (s.in_burst || !due); // RQ8

		// Register bus: one wait cycle, then the answer.
		n.wreq = 1'b1;
		if ((avs_read || avs_write) && s.wreq) begin
			n.wreq = 1'b0;
			unique case (avs_address)
				`IBED_REG_CTRL:      n.rdata = {30'h0, s.ctrl};
				`IBED_REG_SVC_PID:   n.rdata = {19'h0, s.pid};
				`IBED_REG_MAX_DUR:   n.rdata = {16'h0, s.max_ms};
				`IBED_REG_WAKE_LEAD: n.rdata = {24'h0, s.lead};
				`IBED_REG_STATUS:    n.rdata = {25'h0, s.status};
				`IBED_REG_IRQ_MASK:  n.rdata = {25'h0, s.mask};
				`IBED_REG_STATE:     n.rdata = {6'h00, s.count, 8'h00, s.bnum, s.known, s.ifec_end, s.ts_end,
				                                s.in_burst, s.fe_on};
				default:             n.rdata = 32'h00000000;
			endcase
		end
		if (avs_write && !s.wreq) begin
			unique case (avs_address)
				`IBED_REG_CTRL:      n.ctrl = 2'(merge({30'h0, s.ctrl}, avs_writedata, wmask));
				`IBED_REG_SVC_PID:   n.pid = 13'(merge({19'h0, s.pid}, avs_writedata, wmask));
				`IBED_REG_MAX_DUR:   n.max_ms = 16'(merge({16'h0, s.max_ms}, avs_writedata, wmask));
				`IBED_REG_WAKE_LEAD: n.lead = 8'(merge({24'h0, s.lead}, avs_writedata, wmask));
				`IBED_REG_STATUS:    clr = `IBED_ST_W'(avs_writedata & wmask);
				`IBED_REG_IRQ_MASK:  n.mask = `IBED_ST_W'(merge({25'h0, s.mask}, avs_writedata, wmask));
				default:             ;
			endcase
		end

		if (!en) begin
			n.in_burst = 1'b0;
			n.fe_on = 1'b0;
			n.disc = sec_valid;
		end else if (sec_valid) begin
			if (sec_pid != s.pid) begin
				n.disc = 1'b1;
				if (s.in_burst) begin
					n.ts_end = 1'b1; // RQ16
					n.ifec_end = 1'b1; // RQ16
					ev[`IBED_ST_SVC] = 1'b1;
				end
			end else if (stale) begin
				n.disc = 1'b1; // RQ8
				ev[`IBED_ST_LATE] = 1'b1;
			end else begin
				n.acc = 1'b1;
				if (!s.in_burst) begin
					// The new burst is timed from the last anchor of the previous one.
					n.in_burst = 1'b1;
					n.ts_end = 1'b0;
					n.ifec_end = 1'b0;
					n.fe_on = 1'b1;
					n.ref_ms = s.anc_ok ? s.anc_ms : '0;
					n.ref_dt = s.anc_ok ? s.anc_dt : '0;
					n.known = 1'b0;
					n.bnum = s.bnum + 1'b1;
				end
				// Every section of the service that is not stale restarts the anchor: its offset runs from its own packet to the next data start.
				n.anc_ms = '0; // RQ17
				n.anc_dt = sec_delta_t; // RQ1
				n.anc_ok = 1'b1;
				if (sec_is_parity) begin
					if (prot) begin
						n.known = 1'b1;
						n.bnum = sec_burst_num;
						if (sec_mpe_bnd) begin
							n.ts_end = 1'b1; // RQ11
						end
						if (sec_frame_bnd) begin
							n.ifec_end = 1'b1; // RQ12
						end
					end
				end else begin
					if (sec_table_bnd) begin
						n.ts_end = 1'b1; // RQ10
					end
					// Direct release only when nothing older waits, so tags leave in arrival order.
					if (n.known && s.count == '0 && !s.rd_pend) begin
						n.rel_valid = 1'b1;
						n.rel_tag = sec_tag;
						n.rel_num = n.bnum;
					end else if (s.count != BUF_FULL) begin
						push = 1'b1; // RQ6
						n.wptr = s.wptr + 1'b1;
					end else begin
						n.acc = 1'b0;
						n.disc = 1'b1;
						ev[`IBED_ST_OVF] = 1'b1;
					end
				end
			end
		end

		if (en && late) begin
			n.ts_end = 1'b1; // RQ13
			n.ifec_end = 1'b1; // RQ13
			if (!(s.ts_end && s.ifec_end)) begin
				ev[`IBED_ST_TIMEOUT] = 1'b1;
			end
		end
		// Parity sections that lead the data start can slip past; waking early narrows that gap.
		if (en && !s.in_burst && !s.fe_on && (!s.anc_ok || due)) begin
			n.fe_on = 1'b1; // RQ2
		end
		// A protected stream waits for both ends; an unprotected one stops at the data end.
		if (en && s.in_burst && s.ts_end && (s.ifec_end || !prot)) begin // RQ9 RQ14 RQ15
			n.done = 1'b1;
			n.in_burst = 1'b0;
			n.fe_on = 1'b0;
			n.known = 1'b1; // RQ6
			ev[`IBED_ST_DONE] = 1'b1;
		end
		ev[`IBED_ST_TS_END] = n.ts_end && !s.ts_end;
		ev[`IBED_ST_IFEC_END] = n.ifec_end && !s.ifec_end;

		// Drain: held tags go out once the burst number is settled.
		if (s.rd_pend) begin
			n.rel_valid = 1'b1;
			n.rel_tag = ram_q;
			n.rel_num = s.bnum;
		end else if (s.known && s.count != '0) begin
			rd_en = 1'b1; // RQ6
			n.rd_pend = 1'b1;
			n.rptr = s.rptr + 1'b1;
		end
		n.count = s.count + {`IBED_BUF_AW'(0), push} - {`IBED_BUF_AW'(0), rd_en};

		// Set wins over a clear written in the same cycle.
		n.status = (s.status & ~clr) | ev;
		n.irq = |(n.status & n.mask);
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s <= '0;
			s.wreq <= 1'b1;
			s.max_ms <= `IBED_MAX_DUR_RST;
			s.lead <= `IBED_WAKE_LEAD_RST;
		end else begin
			s <= n;
		end
	end

	assign sec_accept = s.acc;
	assign sec_discard = s.disc;
	assign rel_valid = s.rel_valid;
	assign rel_tag = s.rel_tag;
	assign rel_burst_num = s.rel_num;
	assign frontend_on = s.fe_on;
	assign burst_done = s.done;
	assign irq = s.irq;
	assign avs_readdata = s.rdata;
	assign avs_waitrequest = s.wreq;

	sequence s_bus_req;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_svc_hit;
		sec_valid && en && sec_pid != s.pid && s.in_burst && !(s.ts_end && (s.ifec_end || !prot));
	endsequence
	sequence s_both_end_then_off;
		s.ts_end && s.ifec_end ##1 !s.in_burst && s.done;
	endsequence

	chk_bus_answer: assert property (@(posedge clk) disable iff (reset)
		s_bus_req |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer not after one wait cycle");
	chk_done_both: assert property (@(posedge clk) disable iff (reset) // RQ9
		$rose(s.done) |-> $past(s.ts_end) && ($past(s.ifec_end) || !$past(s.ctrl[`IBED_CTRL_PROT])) && !s.fe_on)
		else $error("burst declared over without both ends");
	chk_table_end: assert property (@(posedge clk) disable iff (reset) // RQ10
		sec_valid && en && !sec_is_parity && sec_table_bnd && sec_pid == s.pid && !stale |=> s.ts_end)
		else $error("data boundary flag did not end data burst");
	chk_mpe_end: assert property (@(posedge clk) disable iff (reset) // RQ11
		sec_valid && en && prot && sec_is_parity && sec_mpe_bnd && sec_pid == s.pid && !stale |=> s.ts_end)
		else $error("parity data-boundary flag did not end data burst");
	chk_frame_end: assert property (@(posedge clk) disable iff (reset) // RQ12
		sec_valid && en && prot && sec_is_parity && sec_frame_bnd && sec_pid == s.pid && !stale |=> s.ifec_end)
		else $error("frame flag did not end parity burst");
	chk_late_drop: assert property (@(posedge clk) disable iff (reset) // RQ8
		sec_valid && en && sec_pid == s.pid && stale |=> s.disc && !s.acc) else $error("late section not dropped");
	chk_timeout_end: assert property (@(posedge clk) disable iff (reset) // RQ13
		en && late |=> s.ts_end && s.ifec_end ##1 !s.in_burst) else $error("timeout did not end bursts");
	chk_svc_change: assert property (@(posedge clk) disable iff (reset) // RQ16
		s_svc_hit |=> s_both_end_then_off) else $error("service change did not end bursts");
	chk_stay_on: assert property (@(posedge clk) disable iff (reset) // RQ14
		en && prot && s.in_burst && s.ts_end && !s.ifec_end |=> s.fe_on) else $error("front end off before parity end");
	chk_unprot_off: assert property (@(posedge clk) disable iff (reset) // RQ15
		en && !prot && s.in_burst && s.ts_end |=> s.done && !s.fe_on) else $error("unprotected stream stayed on");
	chk_hold_unknown: assert property (@(posedge clk) disable iff (reset) // RQ6
		sec_valid && en && !sec_is_parity && sec_pid == s.pid && !stale && s.in_burst && !s.known
		&& s.count != BUF_FULL |=> s.count == $past(s.count) + 1'b1) else $error("unnumbered data not buffered");
endmodule

// ### tb/ibed_sec_source.sv
// Section header source standing in for the sending multiplexer.
`timescale 1ns/100ps
module ibed_sec_source (
	// Clock.
	input  wire logic   clk,
	// Section headers.
	output logic        sec_valid,
	output logic        sec_is_parity,
	output logic [12:0] sec_pid,
	output logic        sec_table_bnd,
	output logic        sec_mpe_bnd,
	output logic        sec_frame_bnd,
	output logic [11:0] sec_delta_t,
	output logic [7:0]  sec_burst_num,
	output logic [7:0]  sec_tag
);
	initial begin
		{sec_valid, sec_is_parity, sec_pid, sec_table_bnd, sec_mpe_bnd, sec_frame_bnd} = '0;
		{sec_delta_t, sec_burst_num, sec_tag} = '0;
	end

	// Fields are inverted after each pulse so that stale values cannot pass for live ones.
	task automatic send(input logic [44:0] f);
		@(posedge clk);
		sec_valid <= 1'b1;
		{sec_is_parity, sec_pid, sec_table_bnd, sec_mpe_bnd, sec_frame_bnd, sec_delta_t, sec_burst_num, sec_tag} <= f;
		@(posedge clk);
		sec_valid <= 1'b0;
		{sec_is_parity, sec_pid, sec_table_bnd, sec_mpe_bnd, sec_frame_bnd, sec_delta_t, sec_burst_num, sec_tag} <= ~f;
	endtask
endmodule

// ### tb/testbench.sv
// Self-checking testbench for the burst end detector.
`timescale 1ns/100ps
`include "ibed_defines.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; $display("Error at %0t: got %h expected %h", $time, a, b); end end
module testbench;
	localparam logic [12:0] PID = 13'h0123;
	localparam logic [17:0] ACC = 18'h10000;
	localparam logic [17:0] DIS = 18'h20000;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic [4:0]  avs_address = '0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = '0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        sec_valid, sec_is_parity, sec_table_bnd, sec_mpe_bnd, sec_frame_bnd;
	logic [12:0] sec_pid;
	logic [11:0] sec_delta_t;
	logic [7:0]  sec_burst_num, sec_tag, rel_tag, rel_burst_num, t1, t2;
	logic        sec_accept, sec_discard, rel_valid, frontend_on, burst_done, irq;
	logic [17:0] exp_q[$];
	logic [31:0] rd;
	logic [4:0]  ra [4] = '{`IBED_REG_MAX_DUR, `IBED_REG_WAKE_LEAD, `IBED_REG_CTRL, 5'h1C};
	logic [31:0] rv [4] = '{32'h000000C8, 32'h00000005, 32'h00000000, 32'h00000000};
	int          err_count = 0;
	int          checks = 0;
	int          done_cnt = 0;
	int          seed = 33;

	always #12.5 clk = ~clk;

	ibed_burst_end_detector #(.TICK_CYC(4)) u_ibed_burst_end_detector (
		.clk(clk), .reset(reset), .sec_valid(sec_valid), .sec_is_parity(sec_is_parity), .sec_pid(sec_pid),
		.sec_table_bnd(sec_table_bnd), .sec_mpe_bnd(sec_mpe_bnd), .sec_frame_bnd(sec_frame_bnd),
		.sec_delta_t(sec_delta_t), .sec_burst_num(sec_burst_num), .sec_tag(sec_tag), .sec_accept(sec_accept),
		.sec_discard(sec_discard), .rel_valid(rel_valid), .rel_tag(rel_tag), .rel_burst_num(rel_burst_num),
		.frontend_on(frontend_on), .burst_done(burst_done), .irq(irq), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

	ibed_sec_source u_ibed_sec_source (
		.clk(clk), .sec_valid(sec_valid), .sec_is_parity(sec_is_parity), .sec_pid(sec_pid),
		.sec_table_bnd(sec_table_bnd), .sec_mpe_bnd(sec_mpe_bnd), .sec_frame_bnd(sec_frame_bnd),
		.sec_delta_t(sec_delta_t), .sec_burst_num(sec_burst_num), .sec_tag(sec_tag));

	task automatic report_and_stop;
		$display("Mismatches %0d, comparisons %0d", err_count, checks);
		if (err_count == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// One Avalon access; the request stands until waitrequest is sampled low.
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= ~wr;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic sec(input logic par, input logic [2:0] flg, input logic [12:0] pid, input logic [11:0] dt,
			input logic [7:0] bn, input logic [7:0] tg);
		u_ibed_sec_source.send({par, pid, flg, dt, bn, tg});
	endtask

	task automatic irq_is(input logic v);
		idle(2);
		`CHK(irq, v)
	endtask

	task automatic take(input logic [17:0] got);
		logic [17:0] e;
		if (exp_q.size() == 0) begin
			err_count++;
			$display("Error at %0t: unexpected result %h", $time, got);
		end else begin
			e = exp_q.pop_front();
			`CHK(got, e)
		end
	endtask

	always @(posedge clk) begin
		if (!reset) begin
			if (sec_accept === 1'b1 || sec_discard === 1'b1)
				take(sec_discard === 1'b1 ? DIS : ACC);
			if (rel_valid === 1'b1)
				take({2'h3, rel_tag, rel_burst_num});
			if (burst_done === 1'b1)
				done_cnt++;
		end
	end

	initial begin
		repeat (8000) @(posedge clk);
		err_count++;
		$display("Error at %0t: watchdog expired", $time);
		report_and_stop();
	end

	initial begin
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			bus(0, ra[i], 0);
			`CHK(rd, rv[i])
		end
		exp_q.push_back(DIS);
		sec(0, 3'b000, PID, 12'h002, 8'h00, 8'h01);
		bus(1, `IBED_REG_CTRL, 3);
		bus(1, `IBED_REG_SVC_PID, PID);
		bus(1, `IBED_REG_IRQ_MASK, 1);
		// Data ahead of its number waits for the parity section.
		t1 = $random(seed);
		t2 = $random(seed);
		exp_q.push_back(ACC);
		sec(0, 3'b000, PID, 12'h002, 8'hEE, t1);
		exp_q.push_back(ACC);
		sec(1, 3'b000, PID, 12'h002, 8'h05, 8'h80);
		// The held tag leaves two cycles after the parity section, so the next verdict comes first.
		exp_q.push_back(ACC);
		exp_q.push_back({2'h3, t1, 8'h05});
		exp_q.push_back({2'h3, t2, 8'h05});
		sec(0, 3'b100, PID, 12'h002, 8'hEE, t2);
		idle(8);
		`CHK(done_cnt, 0)
		`CHK(frontend_on, 1'b1)
		exp_q.push_back(ACC);
		sec(1, 3'b001, PID, 12'h002, 8'h05, 8'h81);
		idle(4);
		`CHK(done_cnt, 1)
		`CHK(frontend_on, 1'b0)
		irq_is(1);
		bus(0, `IBED_REG_STATUS, 0);
		`CHK(rd[2:0], 3'h7)
		bus(1, `IBED_REG_IRQ_MASK, 0);
		irq_is(0);
		bus(1, `IBED_REG_IRQ_MASK, 1);
		irq_is(1);
		bus(1, `IBED_REG_STATUS, 32'h7F);
		irq_is(0);
		bus(0, `IBED_REG_STATUS, 0);
		`CHK(rd, 32'h0)
		// Parity flags the data end; a foreign stream then ends the burst.
		exp_q.push_back(ACC);
		sec(1, 3'b010, PID, 12'h001, 8'h09, 8'h82);
		idle(4);
		bus(0, `IBED_REG_STATE, 0);
		`CHK(rd[2], 1'b1)
		`CHK(done_cnt, 1)
		exp_q.push_back(DIS);
		sec(0, 3'b000, 13'h0456, 12'h001, 8'h00, 8'h83);
		idle(4);
		`CHK(done_cnt, 2)
		bus(0, `IBED_REG_STATUS, 0);
		`CHK(rd[5], 1'b1)
		// Without protection the number is predicted from the last burst.
		bus(1, `IBED_REG_CTRL, 1);
		t1 = $random(seed);
		exp_q.push_back(ACC);
		exp_q.push_back({2'h3, t1, 8'h0A});
		sec(0, 3'b100, PID, 12'h001, 8'hEE, t1);
		idle(4);
		`CHK(done_cnt, 3)
		// An open protected burst ends only by timeout.
		bus(1, `IBED_REG_CTRL, 3);
		t2 = $random(seed);
		exp_q.push_back(ACC);
		// A far next burst keeps the stream quiet after the timeout, so a straggler counts as late.
		sec(1, 3'b000, PID, 12'h020, 8'h20, 8'h84);
		exp_q.push_back(ACC);
		exp_q.push_back({2'h3, t2, 8'h20});
		sec(0, 3'b000, PID, 12'h020, 8'hEE, t2);
		for (int i = 0; i < 1500 && done_cnt < 4; i++)
			@(posedge clk);
		`CHK(done_cnt, 4)
		bus(0, `IBED_REG_STATUS, 0);
		`CHK(rd[4], 1'b1)
		idle(80);
		exp_q.push_back(DIS);
		sec(0, 3'b000, PID, 12'h001, 8'hEE, 8'h85);
		idle(4);
		bus(0, `IBED_REG_STATUS, 0);
		`CHK(rd[3], 1'b1)
		`CHK(exp_q.size(), 0)
		report_and_stop();
	end
endmodule
